// ---- hdl/channel_powerdown_decode.sv ----
// Expands one channel's core and buffer fields into per-core power-down levels
`timescale 1ns/1ps
`default_nettype none

module channel_powerdown_decode #(
  parameter int CORES_PER_BUFFER = 2,
  parameter int BUFFERS          = 2
) (
  input  wire logic                                clk,
  input  wire logic                                rst,
  input  wire logic                                apply,
  input  wire logic                                sleep,
  input  wire logic [BUFFERS*CORES_PER_BUFFER-1:0] core_field,
  input  wire logic [1:0]                          buffer_field,
  output logic [BUFFERS*CORES_PER_BUFFER-1:0]      cores_off,
  output logic [BUFFERS-1:0]                       buffers_off
);

  logic [BUFFERS*CORES_PER_BUFFER-1:0] next_cores_off;
  logic [BUFFERS-1:0]                  next_buffers_off;
  logic                                buffer_down;

  // Only 11 counts as off; the forbidden 01/10 leave the buffers running
  assign buffer_down = apply && (buffer_field == powerdown_pkg::BUFFER_OFF);

  // A dead buffer starves the two cores it drives; constant indices keep one driver per bit
  for (genvar b = 0; b < BUFFERS; b++) begin : g_buffer
    assign next_buffers_off[b] = sleep | buffer_down;
    for (genvar c = 0; c < CORES_PER_BUFFER; c++) begin : g_core
      assign next_cores_off[b*CORES_PER_BUFFER+c] =
        sleep | buffer_down | (apply & core_field[b*CORES_PER_BUFFER+c]);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cores_off   <= '0;
      buffers_off <= '0;
    end else begin
      cores_off   <= next_cores_off;
      buffers_off <= next_buffers_off;
    end
  end

endmodule // channel_powerdown_decode

`default_nettype wire

// ---- hdl/power_down_mask_regs.sv ----
// Power-down mask register bank with its serial port and per-channel decode
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Two power-down masks exist; mask one lives at 20h and 21h.
// - Mask two: cores register at 23h, buffers register at 24h.
// - Control powerdown_control bit 5 chooses which mask applies.
// - A mask-enable bit kept elsewhere decides whether masks act at all.
// - Buffer registers: bits 7-6 channel B, 5-4 channel A; 00 keeps active.
// - Buffer field 11 powers down both buffers of that channel.
// - Two buffers per channel, each feeding two cores; four cores per field.
// - Core registers: bits 7-4 channel A, 3-0 channel B.
// - Mask choice 0 applies mask one, 1 applies mask two.
// - With bit 6 set the external power-down pin is ignored.
// - Bit 7 sleeps the whole device; accepted only once bit 6 is set.
module power_down_mask_regs (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       serial_clk,
  input  wire logic       serial_select_n,
  input  wire logic       serial_in,
  input  wire logic       mask_enable,
  input  wire logic       sleep_pin,
  output logic            serial_out,
  output logic            serial_out_oe,
  output logic [3:0]      cores_off_channel_a,
  output logic [3:0]      cores_off_channel_b,
  output logic [1:0]      buffer_off_channel_a,
  output logic [1:0]      buffer_off_channel_b,
  output logic            whole_device_sleep
);

  // ----------------------------------------------------------------------------
  // Configuration port
  // ----------------------------------------------------------------------------
  logic       write_pulse;
  logic [6:0] address;
  logic [7:0] write_data;
  logic [7:0] read_data;

  serial_config_port u_port (
    .clk             (clk),
    .rst             (rst),
    .serial_clk      (serial_clk),
    .serial_select_n (serial_select_n),
    .serial_in       (serial_in),
    .read_data       (read_data),
    .write_pulse     (write_pulse),
    .address         (address),
    .write_data      (write_data),
    .serial_out      (serial_out),
    .serial_out_oe   (serial_out_oe)
  );

  // ----------------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------------
  logic [7:0] core_powerdown_mask_one;
  logic [7:0] buffer_powerdown_mask_one;
  logic [7:0] core_powerdown_mask_two;
  logic [7:0] buffer_powerdown_mask_two;
  logic [7:0] powerdown_control;
  logic [7:0] next_core_one, next_buffer_one;
  logic [7:0] next_core_two, next_buffer_two;
  logic [7:0] next_control;

  // Write decode is shared by the store and the readback
  function automatic logic hit(input logic [6:0] addr, input logic [6:0] target);
    hit = (addr == target);
  endfunction

  // Reserved bits are dropped on write so they can never steer anything
  always_comb begin
    next_core_one   = core_powerdown_mask_one;
    next_buffer_one = buffer_powerdown_mask_one;
    next_core_two   = core_powerdown_mask_two;
    next_buffer_two = buffer_powerdown_mask_two;
    next_control    = powerdown_control;
    if (write_pulse) begin
      if (hit(address, powerdown_pkg::CORE_MASK_ONE_ADDR)) begin
        next_core_one = write_data;
      end
      if (hit(address, powerdown_pkg::BUFFER_MASK_ONE_ADDR)) begin
        next_buffer_one = write_data & powerdown_pkg::BUFFER_WRITE_MASK;
      end
      if (hit(address, powerdown_pkg::CORE_MASK_TWO_ADDR)) begin
        next_core_two = write_data;
      end
      if (hit(address, powerdown_pkg::BUFFER_MASK_TWO_ADDR)) begin
        next_buffer_two = write_data & powerdown_pkg::BUFFER_WRITE_MASK;
      end
      if (hit(address, powerdown_pkg::CONTROL_ADDR)) begin
        next_control = write_data & powerdown_pkg::CONTROL_WRITE_MASK;
        // Sleep bit only moves once the pin override is already in place
        if (!powerdown_control[powerdown_pkg::IGNORE_PIN_BIT]) begin
          next_control[powerdown_pkg::SLEEP_BIT] = powerdown_control[powerdown_pkg::SLEEP_BIT];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      core_powerdown_mask_one   <= powerdown_pkg::CORE_MASK_RESET;
      buffer_powerdown_mask_one <= powerdown_pkg::BUFFER_MASK_RESET;
      core_powerdown_mask_two   <= powerdown_pkg::CORE_MASK_RESET;
      buffer_powerdown_mask_two <= powerdown_pkg::BUFFER_MASK_RESET;
      powerdown_control         <= powerdown_pkg::CONTROL_RESET;
    end else begin
      core_powerdown_mask_one   <= next_core_one;
      buffer_powerdown_mask_one <= next_buffer_one;
      core_powerdown_mask_two   <= next_core_two;
      buffer_powerdown_mask_two <= next_buffer_two;
      powerdown_control         <= next_control;
    end
  end

  // ----------------------------------------------------------------------------
  // Readback
  // ----------------------------------------------------------------------------
  // Unmapped addresses answer zero rather than floating
  always_comb begin
    read_data = powerdown_pkg::UNMAPPED_READ;
    if (hit(address, powerdown_pkg::CORE_MASK_ONE_ADDR)) begin
      read_data = core_powerdown_mask_one;
    end else if (hit(address, powerdown_pkg::BUFFER_MASK_ONE_ADDR)) begin
      read_data = buffer_powerdown_mask_one;
    end else if (hit(address, powerdown_pkg::CORE_MASK_TWO_ADDR)) begin
      read_data = core_powerdown_mask_two;
    end else if (hit(address, powerdown_pkg::BUFFER_MASK_TWO_ADDR)) begin
      read_data = buffer_powerdown_mask_two;
    end else if (hit(address, powerdown_pkg::CONTROL_ADDR)) begin
      read_data = powerdown_control;
    end
  end

  // ----------------------------------------------------------------------------
  // External power-down pin
  // ----------------------------------------------------------------------------
  logic [2:0] pin_sync;
  logic       pin_level;
  logic       next_pin_level;

  // Three stages since the pin is asynchronous to the configuration clock
  always_comb begin
    next_pin_level = (pin_sync[1] == pin_sync[2]) ? pin_sync[2] : pin_level;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_sync  <= 3'h0;
      pin_level <= 1'b0;
    end else begin
      pin_sync  <= {pin_sync[1:0], sleep_pin};
      pin_level <= next_pin_level;
    end
  end

  // ----------------------------------------------------------------------------
  // Mask selection and sleep
  // ----------------------------------------------------------------------------
  logic       choose_two;
  logic       pin_sleep;
  logic       sleep_all;
  logic [7:0] core_sel;
  logic [7:0] buffer_sel;
  logic       next_sleep;

  assign choose_two = powerdown_control[powerdown_pkg::CHOICE_BIT];
  assign core_sel   = choose_two ? core_powerdown_mask_two : core_powerdown_mask_one;
  assign buffer_sel = choose_two ? buffer_powerdown_mask_two : buffer_powerdown_mask_one;

  // Pin is dropped while the override bit is set
  assign pin_sleep  = pin_level & ~powerdown_control[powerdown_pkg::IGNORE_PIN_BIT];
  assign sleep_all  = powerdown_control[powerdown_pkg::SLEEP_BIT] | pin_sleep;

  always_comb begin
    next_sleep = sleep_all;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      whole_device_sleep <= 1'b0;
    end else begin
      whole_device_sleep <= next_sleep;
    end
  end

  // ----------------------------------------------------------------------------
  // Per-channel decode
  // ----------------------------------------------------------------------------
  // Masks act only while the external mask enable is high; sleep overrides all
  channel_powerdown_decode #(
    .CORES_PER_BUFFER (2),
    .BUFFERS          (2)
  ) u_channel_a (
    .clk          (clk),
    .rst          (rst),
    .apply        (mask_enable),
    .sleep        (sleep_all),
    .core_field   (core_sel[powerdown_pkg::CORE_A_MSB:powerdown_pkg::CORE_A_LSB]),
    .buffer_field (buffer_sel[powerdown_pkg::BUFFER_A_MSB:powerdown_pkg::BUFFER_A_LSB]),
    .cores_off    (cores_off_channel_a),
    .buffers_off  (buffer_off_channel_a)
  );

  channel_powerdown_decode #(
    .CORES_PER_BUFFER (2),
    .BUFFERS          (2)
  ) u_channel_b (
    .clk          (clk),
    .rst          (rst),
    .apply        (mask_enable),
    .sleep        (sleep_all),
    .core_field   (core_sel[powerdown_pkg::CORE_B_MSB:powerdown_pkg::CORE_B_LSB]),
    .buffer_field (buffer_sel[powerdown_pkg::BUFFER_B_MSB:powerdown_pkg::BUFFER_B_LSB]),
    .cores_off    (cores_off_channel_b),
    .buffers_off  (buffer_off_channel_b)
  );

endmodule // power_down_mask_regs

`default_nettype wire

// ---- hdl/serial_config_port.sv ----
// Serial configuration port: synchronises the pins, collects frames, returns read data
`timescale 1ns/1ps
`default_nettype none

module serial_config_port (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       serial_clk,
  input  wire logic       serial_select_n,
  input  wire logic       serial_in,
  input  wire logic [7:0] read_data,
  output logic            write_pulse,
  output logic [6:0]      address,
  output logic [7:0]      write_data,
  output logic            serial_out,
  output logic            serial_out_oe
);

  // ----------------------------------------------------------------------------
  // Pin synchronisers: three stages, a change counts when stages two and three agree
  // ----------------------------------------------------------------------------
  logic [2:0] clk_sync, sel_sync, din_sync;
  logic       clk_level, sel_level, din_level;
  logic       next_clk_level, next_sel_level, next_din_level;

  always_comb begin
    next_clk_level = (clk_sync[1] == clk_sync[2]) ? clk_sync[2] : clk_level;
    next_sel_level = (sel_sync[1] == sel_sync[2]) ? sel_sync[2] : sel_level;
    next_din_level = (din_sync[1] == din_sync[2]) ? din_sync[2] : din_level;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      clk_sync  <= 3'h0;
      sel_sync  <= 3'h7;
      din_sync  <= 3'h0;
      clk_level <= 1'b0;
      sel_level <= 1'b1;
      din_level <= 1'b0;
    end else begin
      clk_sync  <= {clk_sync[1:0], serial_clk};
      sel_sync  <= {sel_sync[1:0], serial_select_n};
      din_sync  <= {din_sync[1:0], serial_in};
      clk_level <= next_clk_level;
      sel_level <= next_sel_level;
      din_level <= next_din_level;
    end
  end

  // ----------------------------------------------------------------------------
  // Frame shifter
  // ----------------------------------------------------------------------------
  logic        rise, fall, active;
  logic [15:0] shift;
  logic [4:0]  count;
  logic [7:0]  out_shift;
  logic [15:0] next_shift;
  logic [4:0]  next_count;
  logic [7:0]  next_out_shift;
  logic        next_write_pulse, next_oe;
  logic [6:0]  next_address;
  logic [7:0]  next_write_data;

  assign rise   = next_clk_level & ~clk_level;
  assign fall   = ~next_clk_level & clk_level;
  assign active = ~sel_level;

  // Data in on rising edges, read data out on falling edges of the serial clock
  always_comb begin
    next_shift       = shift;
    next_count       = count;
    next_out_shift   = out_shift;
    next_write_pulse = 1'b0;
    next_address     = address;
    next_write_data  = write_data;
    next_oe          = serial_out_oe;
    if (!active) begin
      next_count = 5'h00;
      next_oe    = 1'b0;
    end else if (rise && count != powerdown_pkg::FRAME_COUNT) begin
      next_shift = {shift[14:0], din_level};
      next_count = count + 5'h01;
      if (count == powerdown_pkg::HEADER_BITS - 5'h01) begin
        next_address = {shift[5:0], din_level};
      end
      if (count == powerdown_pkg::FRAME_COUNT - 5'h01 && !shift[14]) begin
        next_write_data  = {shift[6:0], din_level};
        next_write_pulse = 1'b1;
      end
    end else if (fall && shift[7] && count == powerdown_pkg::HEADER_BITS) begin
      // Header just ended with the read flag: present the addressed register
      next_out_shift = read_data;
      next_oe        = 1'b1;
    end else if (fall && serial_out_oe && count != powerdown_pkg::HEADER_BITS) begin
      next_out_shift = {out_shift[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      shift         <= 16'h0000;
      count         <= 5'h00;
      out_shift     <= 8'h00;
      write_pulse   <= 1'b0;
      address       <= 7'h00;
      write_data    <= 8'h00;
      serial_out_oe <= 1'b0;
    end else begin
      shift         <= next_shift;
      count         <= next_count;
      out_shift     <= next_out_shift;
      write_pulse   <= next_write_pulse;
      address       <= next_address;
      write_data    <= next_write_data;
      serial_out_oe <= next_oe;
    end
  end

  assign serial_out = out_shift[7];

endmodule // serial_config_port

`default_nettype wire

// ---- include/powerdown_pkg.sv ----
// Package of offsets, field positions, reset values and frame layout for the power-down mask bank
package powerdown_pkg;

  // ----------------------------------------------------------------------------
  // Register offsets on the configuration port
  // ----------------------------------------------------------------------------
  localparam logic [6:0] CORE_MASK_ONE_ADDR   = 7'h20;
  localparam logic [6:0] BUFFER_MASK_ONE_ADDR = 7'h21;
  localparam logic [6:0] CORE_MASK_TWO_ADDR   = 7'h23;
  localparam logic [6:0] BUFFER_MASK_TWO_ADDR = 7'h24;
  localparam logic [6:0] CONTROL_ADDR         = 7'h26;

  // ----------------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------------
  localparam logic [7:0] CORE_MASK_RESET    = 8'h00;
  localparam logic [7:0] BUFFER_MASK_RESET  = 8'h00;
  localparam logic [7:0] CONTROL_RESET      = 8'h00;
  localparam logic [7:0] UNMAPPED_READ      = 8'h00;

  // ----------------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------------
  localparam int CORE_A_MSB     = 7;
  localparam int CORE_A_LSB     = 4;
  localparam int CORE_B_MSB     = 3;
  localparam int CORE_B_LSB     = 0;
  localparam int BUFFER_B_MSB   = 7;
  localparam int BUFFER_B_LSB   = 6;
  localparam int BUFFER_A_MSB   = 5;
  localparam int BUFFER_A_LSB   = 4;
  localparam int SLEEP_BIT      = 7;
  localparam int IGNORE_PIN_BIT = 6;
  localparam int CHOICE_BIT     = 5;

  // Writable bits; the rest are reserved, ignored on write and read as zero
  localparam logic [7:0] BUFFER_WRITE_MASK  = 8'hf0;
  localparam logic [7:0] CONTROL_WRITE_MASK = 8'he0;

  // Buffer field encodings
  localparam logic [1:0] BUFFER_ACTIVE = 2'h0;
  localparam logic [1:0] BUFFER_OFF    = 2'h3;

  // ----------------------------------------------------------------------------
  // Serial frame: read flag, 7-bit address, 8-bit data, MSB first
  // ----------------------------------------------------------------------------
  localparam int          FRAME_BITS  = 16;
  localparam logic [4:0]  HEADER_BITS = 5'h08;
  localparam logic [4:0]  FRAME_COUNT = 5'h10;

endpackage

// ---- testbench/power_down_mask_regs_asserts.sv ----
// Checker of port relations for the power-down mask bank
`timescale 1ns/1ps
`default_nettype none

module power_down_mask_regs_asserts (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       serial_select_n,
  input wire logic       mask_enable,
  input wire logic       sleep_pin,
  input wire logic       serial_out_oe,
  input wire logic [3:0] cores_off_channel_a,
  input wire logic [3:0] cores_off_channel_b,
  input wire logic [1:0] buffer_off_channel_a,
  input wire logic [1:0] buffer_off_channel_b,
  input wire logic       whole_device_sleep
);
  // ----------------------------------------------------------------------------
  // Assertions, one clock domain
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Reset leaves every power-down output released
  chk_reset_clears_outputs: assert property ($fell(rst) |-> !whole_device_sleep && cores_off_channel_a == 4'h0
    && cores_off_channel_b == 4'h0 && buffer_off_channel_a == 2'h0 && buffer_off_channel_b == 2'h0)
    else $error("outputs not cleared by reset");
  // A channel's two buffers always go down together
  chk_buf_a_pair: assert property (buffer_off_channel_a inside {2'h0, 2'h3})
    else $error("channel a buffers split");
  chk_buf_b_pair: assert property (buffer_off_channel_b inside {2'h0, 2'h3})
    else $error("channel b buffers split");
  // A buffer that is down starves the cores it feeds
  chk_buf_a_cores: assert property (buffer_off_channel_a == 2'h3 |-> cores_off_channel_a == 4'hf)
    else $error("channel a cores alive without buffers");
  chk_buf_b_cores: assert property (buffer_off_channel_b == 2'h3 |-> cores_off_channel_b == 4'hf)
    else $error("channel b cores alive without buffers");
  // One cycle of slack allows sleep and the decode to land on adjacent edges
  chk_sleep_all_off: assert property (whole_device_sleep && $past(whole_device_sleep) |->
    &{cores_off_channel_a, cores_off_channel_b, buffer_off_channel_a, buffer_off_channel_b})
    else $error("device asleep with parts awake");
  chk_mask_gate_off: assert property ((!mask_enable && !whole_device_sleep) [*4] |->
    {cores_off_channel_a, cores_off_channel_b, buffer_off_channel_a, buffer_off_channel_b} == 12'h000)
    else $error("masks act while disabled");
  chk_oe_idle_frame: assert property (serial_select_n [*6] |-> !serial_out_oe)
    else $error("read data driven outside a frame");
  // Masks change only through register writes, so a quiet port means steady outputs
  chk_outputs_hold_idle: assert property ((serial_select_n && $stable(mask_enable) && $stable(sleep_pin)) [*8]
    |-> $stable({cores_off_channel_a, cores_off_channel_b, buffer_off_channel_a, buffer_off_channel_b}))
    else $error("outputs moved with the port idle");

  cov_sleep: cover property (whole_device_sleep);
  cov_buffer_b_off: cover property (buffer_off_channel_b == 2'h3 && buffer_off_channel_a == 2'h0);
  cov_read_drive: cover property (serial_out_oe);
endmodule // power_down_mask_regs_asserts

bind power_down_mask_regs power_down_mask_regs_asserts chk (.clk(clk), .rst(rst),
  .serial_select_n(serial_select_n), .mask_enable(mask_enable), .sleep_pin(sleep_pin),
  .serial_out_oe(serial_out_oe), .cores_off_channel_a(cores_off_channel_a),
  .cores_off_channel_b(cores_off_channel_b), .buffer_off_channel_a(buffer_off_channel_a),
  .buffer_off_channel_b(buffer_off_channel_b), .whole_device_sleep(whole_device_sleep));

`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench for the power-down mask bank
`timescale 1ns/1ps
`default_nettype none

`define CHECK(what, exp, got) begin checked++; if ((got) !== (exp)) begin mismatches++; \
  $display("Error %s expected %h seen %h", what, exp, got); end end

module tb_top;
  logic       clk;
  logic       rst;
  logic       serial_clk;
  logic       serial_select_n;
  logic       serial_in;
  logic       mask_enable;
  logic       sleep_pin;
  logic       serial_out;
  logic       serial_out_oe;
  logic [3:0] cores_off_channel_a;
  logic [3:0] cores_off_channel_b;
  logic [1:0] buffer_off_channel_a;
  logic [1:0] buffer_off_channel_b;
  logic       whole_device_sleep;
  int         mismatches;
  int         checked;

  power_down_mask_regs dut (.clk(clk), .rst(rst), .serial_clk(serial_clk), .serial_select_n(serial_select_n),
    .serial_in(serial_in), .mask_enable(mask_enable), .sleep_pin(sleep_pin), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .cores_off_channel_a(cores_off_channel_a),
    .cores_off_channel_b(cores_off_channel_b), .buffer_off_channel_a(buffer_off_channel_a),
    .buffer_off_channel_b(buffer_off_channel_b), .whole_device_sleep(whole_device_sleep));

  // ----------------------------------------------------------------------------
  // Clock and port tasks
  // ----------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Six cycles a phase: the pin filter needs three, the read data register one more
  task automatic hold_phase();
    repeat (6) @(negedge clk);
  endtask

  task automatic frame(input logic rd, input logic [6:0] addr, input logic [7:0] data, output logic [7:0] got);
    logic [15:0] bits;
    bits = {rd, addr, data};
    got = 8'h00;
    serial_select_n = 1'b0;
    hold_phase();
    for (int i = 15; i >= 0; i--) begin
      serial_clk = 1'b0;
      serial_in = bits[i];
      hold_phase();
      if (rd && i < 8) begin
        got[i] = serial_out;
        `CHECK("read drive", 1'b1, serial_out_oe)
      end
      serial_clk = 1'b1;
      hold_phase();
    end
    serial_select_n = 1'b1;
    serial_in = ~serial_in; // Released line must not keep its last bit
    hold_phase();
    serial_clk = 1'b0;
    repeat (10) @(negedge clk);
  endtask

  task automatic wr(input logic [6:0] addr, input logic [7:0] data);
    logic [7:0] unused;
    frame(1'b0, addr, data, unused);
  endtask

  task automatic check_reg(input logic [6:0] addr, input logic [7:0] exp);
    logic [7:0] got;
    frame(1'b1, addr, 8'h00, got);
    `CHECK("register read", exp, got)
  endtask

  task automatic check_outs(input logic [3:0] ca, input logic [3:0] cb, input logic [1:0] ba, input logic [1:0] bb,
                            input logic sl);
    `CHECK("cores a", ca, cores_off_channel_a)
    `CHECK("cores b", cb, cores_off_channel_b)
    `CHECK("buffers a", ba, buffer_off_channel_a)
    `CHECK("buffers b", bb, buffer_off_channel_b)
    `CHECK("sleep", sl, whole_device_sleep)
  endtask

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  // Reset values, access kinds, dropped reserved bits and an unmapped place
  task automatic test_register_map();
    check_reg(powerdown_pkg::CORE_MASK_ONE_ADDR, powerdown_pkg::CORE_MASK_RESET);
    check_reg(powerdown_pkg::BUFFER_MASK_ONE_ADDR, powerdown_pkg::BUFFER_MASK_RESET);
    check_reg(powerdown_pkg::CORE_MASK_TWO_ADDR, powerdown_pkg::CORE_MASK_RESET);
    check_reg(powerdown_pkg::BUFFER_MASK_TWO_ADDR, powerdown_pkg::BUFFER_MASK_RESET);
    check_reg(powerdown_pkg::CONTROL_ADDR, powerdown_pkg::CONTROL_RESET);
    wr(powerdown_pkg::CORE_MASK_ONE_ADDR, 8'ha5);
    wr(powerdown_pkg::CORE_MASK_TWO_ADDR, 8'h5a);
    wr(powerdown_pkg::BUFFER_MASK_ONE_ADDR, 8'hff);
    wr(powerdown_pkg::BUFFER_MASK_TWO_ADDR, 8'h3f);
    wr(powerdown_pkg::CONTROL_ADDR, 8'h1f);
    wr(7'h22, 8'h5a);
    check_reg(powerdown_pkg::CORE_MASK_ONE_ADDR, 8'ha5);
    check_reg(powerdown_pkg::CORE_MASK_TWO_ADDR, 8'h5a);
    check_reg(powerdown_pkg::BUFFER_MASK_ONE_ADDR, 8'hff & powerdown_pkg::BUFFER_WRITE_MASK);
    check_reg(powerdown_pkg::BUFFER_MASK_TWO_ADDR, 8'h3f & powerdown_pkg::BUFFER_WRITE_MASK);
    check_reg(powerdown_pkg::CONTROL_ADDR, 8'h1f & powerdown_pkg::CONTROL_WRITE_MASK);
    check_reg(7'h22, powerdown_pkg::UNMAPPED_READ);
    check_outs(4'h0, 4'h0, 2'h0, 2'h0, 1'b0);
  endtask

  // Every documented core pattern and buffer encoding through mask one
  task automatic test_decode();
    logic [7:0] core_vals [3] = '{8'h0f, 8'hf0, 8'hff};
    logic [7:0] buf_vals [4] = '{8'h00, 8'h30, 8'hc0, 8'hf0};
    mask_enable = 1'b1;
    wr(powerdown_pkg::CONTROL_ADDR, 8'h00);
    wr(powerdown_pkg::BUFFER_MASK_ONE_ADDR, 8'h00);
    foreach (core_vals[k]) begin
      wr(powerdown_pkg::CORE_MASK_ONE_ADDR, core_vals[k]);
      check_outs(core_vals[k][7:4], core_vals[k][3:0], 2'h0, 2'h0, 1'b0);
    end
    wr(powerdown_pkg::CORE_MASK_ONE_ADDR, 8'h00);
    foreach (buf_vals[k]) begin
      wr(powerdown_pkg::BUFFER_MASK_ONE_ADDR, buf_vals[k]);
      check_outs({4{buf_vals[k][5]}}, {4{buf_vals[k][7]}}, {2{buf_vals[k][5]}}, {2{buf_vals[k][7]}}, 1'b0);
    end
  endtask

  // Mask choice swaps between two different masks, the enable gates mask two
  task automatic test_mask_choice();
    wr(powerdown_pkg::CORE_MASK_ONE_ADDR, 8'hf0);
    wr(powerdown_pkg::BUFFER_MASK_ONE_ADDR, 8'h00);
    wr(powerdown_pkg::CORE_MASK_TWO_ADDR, 8'h0f);
    wr(powerdown_pkg::BUFFER_MASK_TWO_ADDR, 8'hc0);
    check_outs(4'hf, 4'h0, 2'h0, 2'h0, 1'b0);
    wr(powerdown_pkg::CONTROL_ADDR, 8'h20);
    check_outs(4'h0, 4'hf, 2'h0, 2'h3, 1'b0);
    mask_enable = 1'b0;
    repeat (10) @(negedge clk);
    check_outs(4'h0, 4'h0, 2'h0, 2'h0, 1'b0);
    mask_enable = 1'b1;
  endtask

  // Global sleep refused before the override, the pin, then sleep by register
  task automatic test_sleep();
    wr(powerdown_pkg::CONTROL_ADDR, 8'h80);
    check_reg(powerdown_pkg::CONTROL_ADDR, 8'h00);
    check_outs(4'hf, 4'h0, 2'h0, 2'h0, 1'b0);
    sleep_pin = 1'b1;
    repeat (10) @(negedge clk);
    check_outs(4'hf, 4'hf, 2'h3, 2'h3, 1'b1);
    wr(powerdown_pkg::CONTROL_ADDR, 8'h40);
    check_outs(4'hf, 4'h0, 2'h0, 2'h0, 1'b0);
    wr(powerdown_pkg::CONTROL_ADDR, 8'hc0);
    check_reg(powerdown_pkg::CONTROL_ADDR, 8'hc0);
    sleep_pin = 1'b0;
    repeat (10) @(negedge clk);
    check_outs(4'hf, 4'hf, 2'h3, 2'h3, 1'b1);
    wr(powerdown_pkg::CONTROL_ADDR, 8'h40);
    check_outs(4'hf, 4'h0, 2'h0, 2'h0, 1'b0);
  endtask

  // ----------------------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ----------------------------------------------------------------------------
  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    serial_clk = 1'b0;
    serial_select_n = 1'b1;
    serial_in = 1'b0;
    mask_enable = 1'b0;
    sleep_pin = 1'b0;
    mismatches = 0;
    checked = 0;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    test_register_map();
    test_decode();
    test_mask_choice();
    test_sleep();
    give_verdict();
  end

  // About forty frames of some 214 cycles each; the limit leaves ample margin
  initial begin
    #4000000;
    mismatches++;
    give_verdict();
  end
endmodule // tb_top

`default_nettype wire
